// [hw/dxpp_pkg.sv]
/*
  Shared constants and carrier types for the dual parallel port block.
  Assumes a single 250 MHz core clock and a synchronous active-high reset.
*/
package dxpp_pkg;

  // ----------------------------------------------------------------
  // widths and lanes
  // ----------------------------------------------------------------
  localparam int DXPP_DATA_W = 32;
  localparam int DXPP_CTRL_W = 8;
  localparam int DXPP_LANES = 4;
  localparam int DXPP_CLK_LANE = 1;
  localparam int DXPP_PORTS = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DXPP_CORE_MHZ = 250;
  localparam int DXPP_RX_CLK_NS = 160;
  // half period of the generated receive clock in core cycles
  localparam int DXPP_RX_HALF_CYC = (DXPP_RX_CLK_NS * DXPP_CORE_MHZ) / 2000;
  localparam logic [7:0] DXPP_RX_HALF_LAST = 8'(DXPP_RX_HALF_CYC - 1);

  localparam logic [3:0] DXPP_STATIC_CLKS = 4'h0;
  localparam logic [3:0] DXPP_UPPER_CTRL = 4'h0;
  localparam logic [DXPP_DATA_W-1:0] DXPP_IDLE_DATA = 32'h07070707;
  localparam logic [3:0] DXPP_IDLE_CTRL = 4'hf;

  // one lane-aligned word with its per-lane control bits
  typedef struct packed {
    logic [DXPP_LANES-1:0] ctrl;
    logic [DXPP_DATA_W-1:0] data;
  } dxpp_word_t;

endpackage

// [hw/dxpp_port.sv]
/*
  One parallel port: transmit capture on the lane-1 clock and receive
  launch with a generated lane-1 clock.
  Assumes pins are asynchronous to CORE_CLK and slow enough to sample.
*/
`timescale 1ns/10ps
module dxpp_port import dxpp_pkg::*; (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset, high
  input wire logic [3:0] tx_clks, // transmit clock pins
  input wire logic [DXPP_DATA_W-1:0] tx_data, // transmit data pins
  input wire logic [DXPP_CTRL_W-1:0] tx_ctrl, // transmit control pins
  output dxpp_word_t tx_word, // captured word
  output logic tx_valid, // one-cycle pulse per capture
  input dxpp_word_t rx_word, // word to send
  output logic rx_taken, // pulse when rx_word is launched
  output logic [3:0] rx_clks, // receive clock pins
  output logic [DXPP_DATA_W-1:0] rx_data, // receive data pins
  output logic [DXPP_CTRL_W-1:0] rx_ctrl // receive control pins
);

  // ----------------------------------------------------------------
  // transmit capture
  // ----------------------------------------------------------------
  dxpp_word_t meta_w, sync_w, next_tx_word;
  logic meta_c, sync_c, prev_c, next_tx_valid;
  dxpp_word_t pin_w;
  assign pin_w = '{ctrl: tx_ctrl[DXPP_LANES-1:0], data: tx_data};

  always_comb begin
    next_tx_word = tx_word;
    next_tx_valid = 1'b0;
    if (sync_c && !prev_c) begin
      next_tx_word = sync_w;
      next_tx_valid = 1'b1;
    end
  end

  // data synchronised alongside clock; far side holds it around the edge
  always_ff @(posedge clk) begin
    meta_w <= pin_w;
    sync_w <= meta_w;
    meta_c <= tx_clks[DXPP_CLK_LANE];
    sync_c <= meta_c;
    if (srst) begin
      // follow the pin level so a clock already high is not seen as an edge
      prev_c <= sync_c;
      tx_word <= '0;
      tx_valid <= 1'b0;
    end else begin
      prev_c <= sync_c;
      tx_word <= next_tx_word;
      tx_valid <= next_tx_valid;
    end
  end

  // ----------------------------------------------------------------
  // receive launch
  // ----------------------------------------------------------------
  logic [7:0] cnt, next_cnt;
  logic rclk, next_rclk, next_taken;
  logic [DXPP_DATA_W-1:0] next_rx_data;
  logic [DXPP_LANES-1:0] rx_lane_ctrl, next_rx_lane_ctrl;

  always_comb begin
    next_cnt = cnt + 8'h01;
    next_rclk = rclk;
    next_taken = 1'b0;
    next_rx_data = rx_data;
    next_rx_lane_ctrl = rx_lane_ctrl;
    if (cnt == DXPP_RX_HALF_LAST) begin
      next_cnt = 8'h00;
      next_rclk = !rclk;
      if (rclk) begin
        next_rx_data = rx_word.data;
        next_rx_lane_ctrl = rx_word.ctrl;
        next_taken = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 8'h00;
      rclk <= 1'b0;
      rx_taken <= 1'b0;
      rx_data <= DXPP_IDLE_DATA;
      rx_lane_ctrl <= DXPP_IDLE_CTRL;
    end else begin
      cnt <= next_cnt;
      rclk <= next_rclk;
      rx_taken <= next_taken;
      rx_data <= next_rx_data;
      rx_lane_ctrl <= next_rx_lane_ctrl;
    end
  end

  assign rx_clks = {DXPP_STATIC_CLKS[3:2], rclk, DXPP_STATIC_CLKS[0]};
  assign rx_ctrl = {DXPP_UPPER_CTRL, rx_lane_ctrl};

endmodule

// [hw/dxpp_top.sv]
/*
  Dual parallel port top: two independent ports between pins and core.
  Assumes core logic beyond this block consumes and supplies words.
*/
`timescale 1ns/10ps
module dxpp_top import dxpp_pkg::*; (
  input wire logic CORE_CLK, // core clock
  input wire logic SRST, // sync reset, high
  input wire logic [3:0] PORT0_TRANSMIT_CLOCKS, // port 0 tx clocks
  input wire logic [31:0] PORT0_TRANSMIT_DATA, // port 0 tx data
  input wire logic [7:0] PORT0_TRANSMIT_CONTROL, // port 0 tx control
  input wire logic [3:0] PORT1_TRANSMIT_CLOCKS, // port 1 tx clocks
  input wire logic [31:0] PORT1_TRANSMIT_DATA, // port 1 tx data
  input wire logic [7:0] PORT1_TRANSMIT_CONTROL, // port 1 tx control
  output dxpp_word_t [1:0] TX_WORD, // captured words per port
  output logic [1:0] TX_VALID, // capture pulses
  input dxpp_word_t [1:0] RX_WORD, // words to send per port
  output logic [1:0] RX_TAKEN, // launch pulses
  output logic [3:0] PORT0_RECEIVE_CLOCKS, // port 0 rx clocks
  output logic [31:0] PORT0_RECEIVE_DATA, // port 0 rx data
  output logic [7:0] PORT0_RECEIVE_CONTROL, // port 0 rx control
  output logic [3:0] PORT1_RECEIVE_CLOCKS, // port 1 rx clocks
  output logic [31:0] PORT1_RECEIVE_DATA, // port 1 rx data
  output logic [7:0] PORT1_RECEIVE_CONTROL // port 1 rx control
);

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  // 32-bit transmit buses
  dxpp_port u_port0 (
    .clk(CORE_CLK), .srst(SRST),
    .tx_clks(PORT0_TRANSMIT_CLOCKS), .tx_data(PORT0_TRANSMIT_DATA),
    .tx_ctrl(PORT0_TRANSMIT_CONTROL), .tx_word(TX_WORD[0]), .tx_valid(TX_VALID[0]),
    .rx_word(RX_WORD[0]), .rx_taken(RX_TAKEN[0]), .rx_clks(PORT0_RECEIVE_CLOCKS),
    .rx_data(PORT0_RECEIVE_DATA), .rx_ctrl(PORT0_RECEIVE_CONTROL)
  );

  dxpp_port u_port1 (
    .clk(CORE_CLK), .srst(SRST),
    .tx_clks(PORT1_TRANSMIT_CLOCKS), .tx_data(PORT1_TRANSMIT_DATA),
    .tx_ctrl(PORT1_TRANSMIT_CONTROL), .tx_word(TX_WORD[1]), .tx_valid(TX_VALID[1]),
    .rx_word(RX_WORD[1]), .rx_taken(RX_TAKEN[1]), .rx_clks(PORT1_RECEIVE_CLOCKS),
    .rx_data(PORT1_RECEIVE_DATA), .rx_ctrl(PORT1_RECEIVE_CONTROL)
  );

endmodule

// [tb/dxpp_checker.sv]
/* port 0 receive pin and port 0 and 1 capture pulse assertions;
   assumes a bind into dxpp_top */
`timescale 1ns/10ps
module dxpp_checker import dxpp_pkg::*; (
  input wire logic CORE_CLK, // clock
  input wire logic SRST, // reset
  input dxpp_word_t [1:0] RX_WORD, // words
  input wire logic [1:0] RX_TAKEN, // launch
  input wire logic [1:0] TX_VALID, // capture
  input wire logic [3:0] PORT0_RECEIVE_CLOCKS, // clocks
  input wire logic [7:0] PORT0_RECEIVE_CONTROL // control
);
  wire logic [3:0] rc = PORT0_RECEIVE_CLOCKS;
  wire logic [7:0] rx = PORT0_RECEIVE_CONTROL;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  property p_st; {rc[3:2], rc[0]} == 3'h0; endproperty
  a_st: assert property (p_st) else $error("lane moved");
  property p_hi; $rose(rc[1]) |-> ##19 rc[1] ##1 !rc[1]; endproperty
  a_hi: assert property (p_hi) else $error("high time");
  property p_lo; $fell(rc[1]) |-> ##19 !rc[1] ##1 rc[1]; endproperty
  a_lo: assert property (p_lo) else $error("low time");
  property p_up; rx[7:4] == 4'h0; endproperty
  a_up: assert property (p_up) else $error("upper ctrl");
  property p_tk; $fell(rc[1]) == RX_TAKEN[0]; endproperty
  a_tk: assert property (p_tk) else $error("launch");
  property p_ct; RX_TAKEN[0] |-> rx[3:0] == $past(RX_WORD[0].ctrl); endproperty
  a_ct: assert property (p_ct) else $error("ctrl");
  property p_v0; TX_VALID[0] |=> (!TX_VALID[0]) [*8]; endproperty
  a_v0: assert property (p_v0) else $error("pulse 0");
  property p_v1; TX_VALID[1] |=> (!TX_VALID[1]) [*8]; endproperty
  a_v1: assert property (p_v1) else $error("pulse 1");
  c_rx: cover property (RX_TAKEN[0]);
  c_v0: cover property (TX_VALID[0]);
  c_v1: cover property (TX_VALID[1]);
endmodule
bind dxpp_top dxpp_checker chkr (.CORE_CLK, .SRST, .RX_WORD, .RX_TAKEN, .TX_VALID,
  .PORT0_RECEIVE_CLOCKS, .PORT0_RECEIVE_CONTROL);

// [tb/dxpp_mac_model.sv]
/* far-side transmitter: free lane-1 clock, word launched on its fall;
   assumes the bench supplies the next word */
`timescale 1ns/10ps
module dxpp_mac_model import dxpp_pkg::*; (
  input wire logic [39:0] word, // control and data
  output logic [3:0] clks, // transmit clocks
  output logic [39:0] pins, // control and data pins
  output logic [35:0] sent // word at rising edge
);
  logic c = 1'b0;
  // idle lanes driven, opposite phase to expose misuse
  assign clks = {~c, ~c, c, ~c};
  // word held across the rising edge
  initial begin
    pins = '0;
    sent = '0;
    #13;
    forever begin
      #80 c = ~c;
      if (c) sent = pins[35:0];
      else pins = word;
    end
  end
endmodule

// [tb/testbench.sv]
/* bench for dxpp_top, one far-side model feeds both ports;
   assumes the checker is bound */
`timescale 1ns/10ps
module testbench import dxpp_pkg::*; ;
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  dxpp_word_t [1:0] RX_WORD = '0;
  dxpp_word_t [1:0] TX_WORD, rq;
  logic [1:0] TX_VALID, RX_TAKEN;
  logic [3:0] c0, PORT0_RECEIVE_CLOCKS, PORT1_RECEIVE_CLOCKS;
  logic [39:0] p0, w0 = '0;
  logic [35:0] s0;
  logic [31:0] PORT0_RECEIVE_DATA, PORT1_RECEIVE_DATA;
  logic [7:0] PORT0_RECEIVE_CONTROL, PORT1_RECEIVE_CONTROL;
  logic [47:0] rnd;
  logic [15:0] sd = 16'h74e2;
  int errors = 0, check_count = 0, cyc = 0, ntx = 0;
  dxpp_top uut (.CORE_CLK, .SRST, .PORT0_TRANSMIT_CLOCKS(c0), .PORT0_TRANSMIT_DATA(p0[31:0]),
    .PORT0_TRANSMIT_CONTROL(p0[39:32]), .PORT1_TRANSMIT_CLOCKS(c0),
    .PORT1_TRANSMIT_DATA(p0[31:0]), .PORT1_TRANSMIT_CONTROL(p0[39:32]), .TX_WORD, .TX_VALID,
    .RX_WORD, .RX_TAKEN, .PORT0_RECEIVE_CLOCKS, .PORT0_RECEIVE_DATA, .PORT0_RECEIVE_CONTROL,
    .PORT1_RECEIVE_CLOCKS, .PORT1_RECEIVE_DATA, .PORT1_RECEIVE_CONTROL);
  dxpp_mac_model m0 (.word(w0), .clks(c0), .pins(p0), .sent(s0));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [39:0] pins(input dxpp_word_t w);
    return {4'h0, w.ctrl, w.data};
  endfunction
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #2 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    rq <= RX_WORD;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      test_done();
    end
  end
  always @(negedge CORE_CLK) begin
    if (TX_VALID[0] === 1'b1) ntx++;
    if (TX_VALID[0] === 1'b1) chk("tx 0", 40'(TX_WORD[0]), 40'(s0));
    if (TX_VALID[1] === 1'b1) chk("tx 1", 40'(TX_WORD[1]), 40'(s0));
    if (RX_TAKEN[0] === 1'b1) begin
      chk("rx 0", {PORT0_RECEIVE_CONTROL, PORT0_RECEIVE_DATA}, pins(rq[0]));
    end
    if (RX_TAKEN[1] === 1'b1) begin
      chk("rx 1", {PORT1_RECEIVE_CONTROL, PORT1_RECEIVE_DATA}, pins(rq[1]));
      // lane 1 has just fallen at launch, the other lanes never move
      chk("rclk 1", 40'(PORT1_RECEIVE_CLOCKS), 40'h0);
    end
  end
  initial begin
    for (int r = 0; r < 2; r++) begin
      SRST = 1'b1;
      repeat (5) @(posedge CORE_CLK);
      #1 SRST = 1'b0;
      chk("idle", {PORT0_RECEIVE_CONTROL, PORT0_RECEIVE_DATA},
        pins({DXPP_IDLE_CTRL, DXPP_IDLE_DATA}));
      for (int n = 0; n < 1500; n++) begin
        @(posedge CORE_CLK);
        #1 sd = lfsr(sd);
        rnd = {sd, lfsr(sd), lfsr(lfsr(sd))};
        // corners first: all-ones or all-zero words with unused control set
        if (r == 0 && n < 160) rnd = {4'hf, {44{n[5]}}};
        RX_WORD = {rnd[35:0], rnd[47:12]};
        w0 = rnd[47:8];
      end
    end
    chk("tx count", 40'(ntx > 60), 40'h1);
    test_done();
  end
endmodule
